// *** i2cm_consts.vh ***
// Constants for the two-wire multimaster bus controller
`ifndef I2CM_CONSTS_VH
`define I2CM_CONSTS_VH

// System clock period
`define I2CM_CLK_PS       5000
// Quarter bit periods per speed category
`define I2CM_QTR_STD_PS   2500000
`define I2CM_QTR_FAST_PS  625000
`define I2CM_QTR_FP_PS    250000
`define I2CM_QTR_HS_PS    73530
// Quarter periods in clock cycles, rounded up
`define I2CM_QTR_STD_CYC  ((`I2CM_QTR_STD_PS + `I2CM_CLK_PS - 1) / `I2CM_CLK_PS)
`define I2CM_QTR_FAST_CYC ((`I2CM_QTR_FAST_PS + `I2CM_CLK_PS - 1) / `I2CM_CLK_PS)
`define I2CM_QTR_FP_CYC   ((`I2CM_QTR_FP_PS + `I2CM_CLK_PS - 1) / `I2CM_CLK_PS)
`define I2CM_QTR_HS_CYC   ((`I2CM_QTR_HS_PS + `I2CM_CLK_PS - 1) / `I2CM_CLK_PS)
`define I2CM_DIV_W        10

// Speed selection
`define I2CM_SPD_STD      2'h0
`define I2CM_SPD_FAST     2'h1
`define I2CM_SPD_FP       2'h2

// Command operations
`define I2CM_OP_START     2'h0
`define I2CM_OP_WRITE     2'h1
`define I2CM_OP_READ      2'h2
`define I2CM_OP_STOP      2'h3

// Master code group and byte layout
`define I2CM_MC_GROUP     5'h01
`define I2CM_ACK_BIT      4'h8
`define I2CM_READ_FILL    8'hff
`define I2CM_LAST_PH      3'h4

// Deglitch length in cycles
`define I2CM_GLITCH_CYC   2'h3
`define I2CM_GLITCH_W     2

// Open-drain drive level
`define I2CM_LINE_LOW     1'b0

`endif

// *** i2cm_line_filter.v ***
// Synchroniser and deglitch filter for the two bus lines
`timescale 1ns/1ps
`include "i2cm_consts.vh"

module i2cm_line_filter
(
   input  wire       clk,
   input  wire       rst,
   input  wire [1:0] lineIn,
   output wire [1:0] lineOut
);

   genvar i;

   generate
      for (i = 0; i < 2; i = i + 1)
      begin : gLine
         reg                      sync1_reg;
         reg                      sync2_reg;
         reg                      out_reg;
         reg [`I2CM_GLITCH_W-1:0] cnt_reg;

         always @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               sync1_reg <= 1'b1;
               sync2_reg <= 1'b1;
               out_reg   <= 1'b1;
               cnt_reg   <= {`I2CM_GLITCH_W{1'b0}};
            end
            else
            begin
               sync1_reg <= lineIn[i];
               sync2_reg <= sync1_reg;
               // New level must persist before it is taken
               if (sync2_reg == out_reg)
                  cnt_reg <= {`I2CM_GLITCH_W{1'b0}};
               else if (cnt_reg == `I2CM_GLITCH_CYC - 2'h1)
               begin
                  out_reg <= sync2_reg;
                  cnt_reg <= {`I2CM_GLITCH_W{1'b0}};
               end
               else
                  cnt_reg <= cnt_reg + 2'h1;
            end
         end

         assign lineOut[i] = out_reg;
      end
   endgenerate

endmodule

// *** i2cm_rate_div.v ***
// Quarter bit period tick divider
`timescale 1ns/1ps
`include "i2cm_consts.vh"

module i2cm_rate_div
(
   input  wire       clk,
   input  wire       rst,
   input  wire [1:0] rateSel,
   input  wire       hsMode,
   output reg        tick
);

   reg  [`I2CM_DIV_W-1:0] cnt_reg;
   reg  [`I2CM_DIV_W-1:0] reload;

   // ****************************************
   // Reload value per speed
   // ****************************************
   localparam integer RLD_STD  = `I2CM_QTR_STD_CYC - 1;
   localparam integer RLD_FAST = `I2CM_QTR_FAST_CYC - 1;
   localparam integer RLD_FP   = `I2CM_QTR_FP_CYC - 1;
   localparam integer RLD_HS   = `I2CM_QTR_HS_CYC - 1;

   always @*
   begin
      if (hsMode)
         reload = RLD_HS[`I2CM_DIV_W-1:0];
      else if (rateSel == `I2CM_SPD_FAST)
         reload = RLD_FAST[`I2CM_DIV_W-1:0];
      else if (rateSel == `I2CM_SPD_FP)
         reload = RLD_FP[`I2CM_DIV_W-1:0];
      else
         reload = RLD_STD[`I2CM_DIV_W-1:0];
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg <= {`I2CM_DIV_W{1'b0}};
         tick    <= 1'b0;
      end
      else if (cnt_reg == {`I2CM_DIV_W{1'b0}})
      begin
         cnt_reg <= reload;
         tick    <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg - 1'b1;
         tick    <= 1'b0;
      end
   end

endmodule

// *** i2cm_master.v ***
// Two-wire multimaster bus controller, byte level command engine
// Behaviour
// [RULE_01] Master makes the clock line and alone starts and ends transfers.
// [RULE_02] Lines are only pulled low or released, never driven high.
// [RULE_03] Start: data line falls while clock line is high.
// [RULE_04] After a start the bus is busy for every participant.
// [RULE_05] After start, send seven address bits then one direction bit.
// [RULE_06] Only the slave whose address matches acknowledges.
// [RULE_07] Data phase follows only after the address was acknowledged.
// [RULE_08] Write: place bit on data line, then one clock pulse.
// [RULE_09] Read: release data line, pulse clock, sample while clock high.
// [RULE_10] Data line never changes while clock high, except start/stop.
// [RULE_11] Stop: data line rises while clock high; bus then free.
// [RULE_12] After releasing a line, sample it to see it went high.
// [RULE_13] Data low after release means arbitration lost; wait for stop.
// [RULE_14] Four speeds: standard, fast, fast-plus and high-speed.
// [RULE_15] Slaves answer a seven-bit address, upper four fixed, lower three pins.
// [RULE_16] Each high-speed master owns a unique three-bit master code.
// [RULE_17] High-speed transfer opens with start and master code at slow rate.
// [RULE_18] Master code is never acknowledged; its ack slot stays high.
// [RULE_19] After master code: repeated start, then bytes at high-speed rate.
// [RULE_20] In high-speed mode arbitration is checked only during master code.
// [RULE_21] Master code is group 00001 then the three own code bits.
// [RULE_22] Released clock must go high; wait while a slave holds it low.
// [RULE_23] Polling resends start, address and direction until acknowledged.
// [RULE_24] Each byte has a ninth pulse where the receiver acknowledges low.
// [RULE_25] Both incoming lines are synchronised and deglitched before use.
`timescale 1ns/1ps
`include "i2cm_consts.vh"

module i2cm_master
(
   input  wire       clk,
   input  wire       rst,
   input  wire [1:0] speedSel,
   input  wire [2:0] masterCode,
   input  wire       cmdValid,
   output wire       cmdReady,
   input  wire [1:0] cmdOp,
   input  wire [7:0] cmdData,
   input  wire       cmdHs,
   input  wire       cmdPoll,
   input  wire       cmdNack,
   output reg        rspValid,
   output reg  [7:0] rspData,
   output reg        rspAck,
   output reg        arbLost,
   output reg        busBusy,
   input  wire       sclIn,
   output wire       sclOut,
   output wire       sclOe,
   input  wire       sdaIn,
   output wire       sdaOut,
   output wire       sdaOe
);

   // ****************************************
   // States
   // ****************************************
   localparam ST_IDLE  = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_BIT   = 3'h2;
   localparam ST_HOLD  = 3'h3;
   localparam ST_STOP  = 3'h4;
   localparam ST_LOST  = 3'h5;

   reg  [2:0] state_reg;
   reg  [2:0] ph_reg;
   reg  [3:0] bitCnt_reg;
   reg  [8:0] shift_reg;
   reg  [8:0] rxShift_reg;
   reg  [7:0] addrByte_reg;
   reg        sclLow_reg;
   reg        sdaLow_reg;
   reg        hsActive_reg;
   reg        mcPhase_reg;
   reg        txOwn_reg;
   reg        isAddr_reg;
   reg        poll_reg;
   reg        sdaPrev_reg;

   wire [1:0] lineF;
   wire       sclF;
   wire       sdaF;
   wire       tick;
   wire       take;
   wire       ackLow;

   // ****************************************
   // Line conditioning and rate
   // ****************************************
   i2cm_line_filter uFilter
   (
      .clk     (clk),
      .rst     (rst),
      .lineIn  ({sclIn, sdaIn}),
      .lineOut (lineF)
   );

   assign sclF = lineF[1];
   assign sdaF = lineF[0];   // [RULE_25]

   i2cm_rate_div uDiv
   (
      .clk     (clk),
      .rst     (rst),
      .rateSel (speedSel),
      .hsMode  (hsActive_reg),
      .tick    (tick)
   );   // [RULE_14]

   // Open drain: output level fixed low, enable pulls the line
   assign sclOut = `I2CM_LINE_LOW;
   assign sdaOut = `I2CM_LINE_LOW;
   assign sclOe  = sclLow_reg;   // [RULE_01] [RULE_02]
   assign sdaOe  = sdaLow_reg;   // [RULE_02]

   assign cmdReady = ((state_reg == ST_IDLE) && !busBusy) || (state_reg == ST_HOLD);
   assign take     = cmdValid && cmdReady;
   assign ackLow   = ~rxShift_reg[0];

   // ****************************************
   // Bus monitor
   // ****************************************
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sdaPrev_reg <= 1'b1;
         busBusy     <= 1'b0;
      end
      else
      begin
         sdaPrev_reg <= sdaF;
         if (sclF && sdaPrev_reg && !sdaF)
            busBusy <= 1'b1;   // [RULE_04]
         else if (sclF && !sdaPrev_reg && sdaF)
            busBusy <= 1'b0;   // [RULE_11]
      end
   end

   // ****************************************
   // Transfer engine
   // ****************************************
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg    <= ST_IDLE;
         ph_reg       <= 3'h0;
         bitCnt_reg   <= 4'h0;
         shift_reg    <= 9'h1ff;
         rxShift_reg  <= 9'h1ff;
         addrByte_reg <= 8'h00;
         sclLow_reg   <= 1'b0;
         sdaLow_reg   <= 1'b0;
         hsActive_reg <= 1'b0;
         mcPhase_reg  <= 1'b0;
         txOwn_reg    <= 1'b0;
         isAddr_reg   <= 1'b0;
         poll_reg     <= 1'b0;
         rspValid     <= 1'b0;
         rspData      <= 8'h00;
         rspAck       <= 1'b0;
         arbLost      <= 1'b0;
      end
      else
      begin
         rspValid <= 1'b0;
         arbLost  <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               sclLow_reg   <= 1'b0;
               sdaLow_reg   <= 1'b0;
               hsActive_reg <= 1'b0;
               if (take && (cmdOp == `I2CM_OP_START))
               begin
                  addrByte_reg <= cmdData;
                  poll_reg     <= cmdPoll;
                  mcPhase_reg  <= cmdHs;   // [RULE_17]
                  ph_reg       <= 3'h0;
                  state_reg    <= ST_START;
               end
            end

            ST_START:
            begin
               if (tick)
               begin
                  case (ph_reg)
                     3'h0:
                     begin
                        sdaLow_reg <= 1'b0;   // [RULE_10]
                        ph_reg     <= 3'h1;
                     end
                     3'h1:
                     begin
                        sclLow_reg <= 1'b0;
                        ph_reg     <= 3'h2;
                     end
                     3'h2:
                     begin
                        if (!sdaF && !busBusy && sclF)
                        begin
                           arbLost   <= 1'b1;   // [RULE_12] [RULE_13]
                           state_reg <= ST_LOST;
                        end
                        else if (sclF && sdaF)
                           ph_reg <= 3'h3;   // [RULE_22]
                     end
                     3'h3:
                     begin
                        sdaLow_reg <= 1'b1;   // [RULE_03]
                        ph_reg     <= `I2CM_LAST_PH;
                     end
                     default:
                     begin
                        sclLow_reg <= 1'b1;
                        bitCnt_reg <= 4'h0;
                        txOwn_reg  <= 1'b1;
                        ph_reg     <= 3'h0;
                        state_reg  <= ST_BIT;
                        if (mcPhase_reg)
                        begin
                           shift_reg  <= {`I2CM_MC_GROUP, masterCode, 1'b1};   // [RULE_16] [RULE_21]
                           isAddr_reg <= 1'b0;
                        end
                        else
                        begin
                           shift_reg  <= {addrByte_reg, 1'b1};   // [RULE_05]
                           isAddr_reg <= 1'b1;
                        end
                     end
                  endcase
               end
            end

            ST_BIT:
            begin
               if (tick)
               begin
                  case (ph_reg)
                     3'h0:
                     begin
                        sdaLow_reg <= ~shift_reg[8];   // [RULE_08] [RULE_09] [RULE_24]
                        ph_reg     <= 3'h1;
                     end
                     3'h1:
                     begin
                        sclLow_reg <= 1'b0;
                        ph_reg     <= 3'h2;
                     end
                     3'h2:
                     begin
                        if (sclF)
                        begin
                           rxShift_reg <= {rxShift_reg[7:0], sdaF};   // [RULE_09] [RULE_22]
                           ph_reg      <= 3'h3;
                           if (txOwn_reg && (bitCnt_reg < `I2CM_ACK_BIT) && shift_reg[8]
                               && !sdaF && !hsActive_reg)
                           begin
                              arbLost    <= 1'b1;   // [RULE_12] [RULE_13] [RULE_20]
                              sclLow_reg <= 1'b0;
                              sdaLow_reg <= 1'b0;
                              state_reg  <= ST_LOST;
                           end
                        end
                     end
                     default:
                     begin
                        sclLow_reg <= 1'b1;
                        shift_reg  <= {shift_reg[7:0], 1'b1};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                        ph_reg     <= 3'h0;
                        if (bitCnt_reg == `I2CM_ACK_BIT)
                        begin
                           if (mcPhase_reg)
                           begin
                              mcPhase_reg  <= 1'b0;   // [RULE_18]
                              hsActive_reg <= 1'b1;   // [RULE_19]
                              state_reg    <= ST_START;
                           end
                           else if (isAddr_reg && !ackLow && poll_reg)
                              state_reg <= ST_START;   // [RULE_23]
                           else
                           begin
                              rspValid  <= 1'b1;
                              rspData   <= rxShift_reg[8:1];
                              rspAck    <= ackLow;
                              state_reg <= (isAddr_reg && !ackLow) ? ST_STOP : ST_HOLD;   // [RULE_07]
                           end
                        end
                     end
                  endcase
               end
            end

            ST_HOLD:
            begin
               if (take)
               begin
                  ph_reg     <= 3'h0;
                  bitCnt_reg <= 4'h0;
                  if (cmdOp == `I2CM_OP_WRITE)
                  begin
                     shift_reg  <= {cmdData, 1'b1};
                     txOwn_reg  <= 1'b1;
                     isAddr_reg <= 1'b0;
                     state_reg  <= ST_BIT;
                  end
                  else if (cmdOp == `I2CM_OP_READ)
                  begin
                     shift_reg  <= {`I2CM_READ_FILL, cmdNack};   // [RULE_24]
                     txOwn_reg  <= 1'b0;
                     isAddr_reg <= 1'b0;
                     state_reg  <= ST_BIT;
                  end
                  else if (cmdOp == `I2CM_OP_START)
                  begin
                     addrByte_reg <= cmdData;
                     poll_reg     <= cmdPoll;
                     mcPhase_reg  <= cmdHs && !hsActive_reg;
                     state_reg    <= ST_START;
                  end
                  else
                     state_reg <= ST_STOP;
               end
            end

            ST_STOP:
            begin
               if (tick)
               begin
                  case (ph_reg)
                     3'h0:
                     begin
                        sdaLow_reg <= 1'b1;
                        ph_reg     <= 3'h1;
                     end
                     3'h1:
                     begin
                        sclLow_reg <= 1'b0;
                        ph_reg     <= 3'h2;
                     end
                     3'h2:
                     begin
                        if (sclF)
                           ph_reg <= 3'h3;   // [RULE_22]
                     end
                     3'h3:
                     begin
                        sdaLow_reg <= 1'b0;   // [RULE_11]
                        ph_reg     <= `I2CM_LAST_PH;
                     end
                     default:
                     begin
                        ph_reg    <= 3'h0;
                        state_reg <= ST_IDLE;
                     end
                  endcase
               end
            end

            default:
            begin
               sclLow_reg   <= 1'b0;
               sdaLow_reg   <= 1'b0;
               hsActive_reg <= 1'b0;
               mcPhase_reg  <= 1'b0;
               if (!busBusy)
                  state_reg <= ST_IDLE;   // [RULE_13]
            end
         endcase
      end
   end

endmodule

// *** i2cm_master_chk.sv ***
// Port level checks for the two-wire bus controller
`timescale 1ns/1ps
`include "i2cm_consts.vh"
module i2cm_master_chk
(
   input wire       clk,
   input wire       rst,
   input wire       cmdValid,
   input wire       cmdReady,
   input wire [1:0] cmdOp,
   input wire       arbLost,
   input wire       busBusy,
   input wire       sclIn,
   input wire       sclOut,
   input wire       sclOe,
   input wire       sdaIn,
   input wire       sdaOut,
   input wire       sdaOe
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   od_pins_a: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
      else $error("Pin driven high");
   start_edge_a: assert property ($rose(sdaOe) && !sclOe |-> sclIn)
      else $error("Start without clock high");
   stop_free_a: assert property ($fell(sdaOe) && !sclOe |-> ##[1:12] !busBusy)
      else $error("Data change with clock high not a stop");
   start_busy_a: assert property ($fell(sdaIn) && sclIn ##1 (!sdaIn && sclIn)[*5]
      |-> ##[0:6] busBusy) else $error("Start not seen");
   stop_seen_a: assert property ($rose(sdaIn) && sclIn ##1 (sdaIn && sclIn)[*5]
      |-> ##[0:6] !busBusy) else $error("Stop not seen");
   glitch_rej_a: assert property (!busBusy && sclIn && $fell(sdaIn) ##1 $rose(sdaIn)
      |=> !busBusy[*8]) else $error("Glitch taken as start");
   arb_release_a: assert property (arbLost |=> (!sdaOe && !sclOe)[*8])
      else $error("Lines held after lost arbitration");
   arb_cause_a: assert property (arbLost |-> !sdaOe && !sdaIn)
      else $error("Arbitration lost without low line");
   stretch_wait_a: assert property (!sclOe && !sclIn |=> !sclOe)
      else $error("Clock pulled while held low");
   start_taken_a: assert property (cmdValid && cmdReady && cmdOp == `I2CM_OP_START
      |=> !cmdReady) else $error("Ready during start");
endmodule

// *** i2cm_slave_model.sv ***
// Behavioural slave peripheral on the two-wire bus
`timescale 1ns/1ps
module i2cm_slave_model
#(
   parameter [6:0] ADDR = 7'h52,
   parameter [7:0] TXB  = 8'h3c
)
(
   input  wire       scl,
   input  wire       sda,
   input  wire       ackEn,
   input  wire       stretch,
   output reg        sdaPull,
   output reg        sclPull,
   output reg  [7:0] rxByte,
   output reg  [7:0] addrByte,
   output reg  [7:0] prevAddr,
   output reg  [7:0] startCnt
);
   reg [3:0] bitCnt;
   reg [7:0] sh;
   reg [7:0] txByte;
   reg       inAddr, matched, rw;
   // ****************
   // Bus behaviour
   // ****************
   initial
   begin
      {sdaPull, sclPull, inAddr, matched, rw} = 5'h00;
      {rxByte, addrByte, prevAddr, startCnt, sh} = 40'h0;
      bitCnt = 4'h0;
      txByte = TXB;
   end
   always @(negedge sda)
      if (scl)
      begin
         bitCnt = 4'h0;
         inAddr = 1'b1;
         matched = 1'b0;
         startCnt = startCnt + 8'h01;
      end
   always @(posedge sda)
      if (scl)
         matched = 1'b0;
   always @(posedge scl)
   begin
      if (bitCnt < 4'h8)
         sh = {sh[6:0], sda};
      else if (matched && rw && !inAddr)
      begin
         matched = !sda;
         txByte = txByte + 8'h01;
      end
      bitCnt = bitCnt + 4'h1;
   end
   always @(negedge scl)
      if (bitCnt == 4'h8)
      begin
         if (inAddr)
         begin
            prevAddr = addrByte;
            addrByte = sh;
            rw = sh[0];
            matched = ackEn && sh[7:1] == ADDR;
         end
         else
            rxByte = sh;
         sdaPull <= #10 matched && !(rw && !inAddr);
      end
      else if (bitCnt == 4'h9)
      begin
         bitCnt = 4'h0;
         inAddr = 1'b0;
         sdaPull <= #10 matched && rw && !txByte[7];
      end
      else
         sdaPull <= #10 matched && rw && !inAddr && !txByte[3'h7 - bitCnt[2:0]];
   always @(negedge scl)
      if (stretch && bitCnt == 4'h8)
      begin
         sclPull = 1'b1;
         #2000 sclPull = 1'b0;
      end
endmodule

// *** i2cm_master_tb.sv ***
// Self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
`include "i2cm_consts.vh"
module i2cm_master_tb;
   localparam [6:0] SLV = 7'h52;
   localparam [7:0] TXB = 8'h3c;
   reg        clk, rst, cmdValid, cmdHs, cmdPoll, cmdNack, ackEn, stretch, rivalPull;
   reg  [1:0] speedSel, cmdOp;
   reg  [2:0] masterCode;
   reg  [7:0] cmdData;
   wire       cmdReady, rspValid, rspAck, arbLost, busBusy, slvSda, slvScl;
   wire       sclOut, sclOe, sdaOut, sdaOe;
   wire [7:0] rspData, slvRx, slvAddr, slvPrev, slvStarts;
   integer    errorCnt, checked, hiCnt, lastHi, s0;
   wire       scl = !(sclOe || slvScl);
   wire       sda = !(sdaOe || slvSda || rivalPull);
   i2cm_master i2cm_master_i
   (
      .clk(clk), .rst(rst), .speedSel(speedSel), .masterCode(masterCode),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdData(cmdData),
      .cmdHs(cmdHs), .cmdPoll(cmdPoll), .cmdNack(cmdNack), .rspValid(rspValid),
      .rspData(rspData), .rspAck(rspAck), .arbLost(arbLost), .busBusy(busBusy),
      .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut),
      .sdaOe(sdaOe)
   );
   i2cm_slave_model #(.ADDR(SLV), .TXB(TXB)) i2cm_slave_model_i
   (
      .scl(scl), .sda(sda), .ackEn(ackEn), .stretch(stretch), .sdaPull(slvSda),
      .sclPull(slvScl), .rxByte(slvRx), .addrByte(slvAddr), .prevAddr(slvPrev),
      .startCnt(slvStarts)
   );
   // ****************
   // Tasks
   // ****************
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
      if (scl)
         hiCnt <= hiCnt + 1;
      else
      begin
         if (hiCnt > 0)
            lastHi <= hiCnt;
         hiCnt <= 0;
      end
   task endSim;
   begin
      if (errorCnt == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   task chk(input [63:0] name, input [15:0] exp, input [15:0] got);
   begin
      checked = checked + 1;
      if (got !== exp)
      begin
         errorCnt = errorCnt + 1;
         $display("Error %0s expected %h seen %h", name, exp, got);
      end
   end
   endtask
   function sel(input integer k);
      case (k)
         0: sel = rspValid;
         1: sel = ~busBusy;
         2: sel = arbLost;
         3: sel = sclOe;
         default: sel = cmdReady;
      endcase
   endfunction
   task waitOn(input integer k);
      integer i;
   begin
      i = 0;
      while (sel(k) !== 1'b1 && i < 40000)
      begin
         i = i + 1;
         @(negedge clk);
      end
      if (i == 40000)
      begin
         chk("wait", 16'h1, 16'h0);
         endSim;
      end
      @(negedge clk);
   end
   endtask
   task cmd(input [1:0] op, input [7:0] d, input hs, input poll, input nack);
   begin
      @(negedge clk);
      {cmdValid, cmdOp, cmdData, cmdHs, cmdPoll, cmdNack} = {1'b1, op, d, hs, poll, nack};
      waitOn(5);
      cmdValid = 1'b0;
   end
   endtask
   task xfer(input [1:0] op, input [7:0] d, input hs, input poll, input nack);
   begin
      cmd(op, d, hs, poll, nack);
      waitOn(0);
   end
   endtask
   task stop;
   begin
      cmd(`I2CM_OP_STOP, 8'h00, 1'b0, 1'b0, 1'b0);
      waitOn(1);
      chk("busy", 16'h0, {busBusy, sclOe, sdaOe});
   end
   endtask
   // ****************
   // Scenarios
   // ****************
   task tIdle;
   begin
      chk("ready", 16'h1, cmdReady);
      chk("oe", 16'h0, {sclOe, sdaOe});
      rivalPull = 1'b1;
      @(negedge clk) rivalPull = 1'b0;
      repeat (20) @(negedge clk);
      chk("glitch", 16'h0, busBusy);
   end
   endtask
   task tWrite;
   begin
      stretch = 1'b1;
      xfer(`I2CM_OP_START, {SLV, 1'b0}, 1'b0, 1'b0, 1'b0);
      chk("addrAck", 16'h1, rspAck);
      chk("addrByte", {SLV, 1'b0}, slvAddr);
      xfer(`I2CM_OP_WRITE, 8'ha5, 1'b0, 1'b0, 1'b0);
      chk("wrAck", 16'h1, rspAck);
      chk("wrByte", 16'ha5, slvRx);
      stretch = 1'b0;
      stop;
   end
   endtask
   task tRead;
   begin
      xfer(`I2CM_OP_START, {SLV, 1'b1}, 1'b0, 1'b0, 1'b0);
      xfer(`I2CM_OP_READ, 8'h00, 1'b0, 1'b0, 1'b0);
      chk("rd0", {8'h1, TXB}, {rspAck, rspData});
      xfer(`I2CM_OP_READ, 8'h00, 1'b0, 1'b0, 1'b1);
      chk("rd1", {8'h0, TXB + 8'h01}, {rspAck, rspData});
      stop;
   end
   endtask
   task tNack;
   begin
      xfer(`I2CM_OP_START, 8'h22, 1'b0, 1'b0, 1'b0);
      chk("nack", 16'h0, rspAck);
      waitOn(1);
      ackEn = 1'b0;
      s0 = slvStarts;
      cmd(`I2CM_OP_START, {SLV, 1'b0}, 1'b0, 1'b1, 1'b0);
      repeat (5000) @(negedge clk);
      ackEn = 1'b1;
      waitOn(0);
      chk("poll", 16'h1, rspAck && slvStarts - s0 > 1);
      stop;
   end
   endtask
   task tHs;
   begin
      masterCode = 3'h5;
      s0 = slvStarts;
      xfer(`I2CM_OP_START, {SLV, 1'b0}, 1'b1, 1'b0, 1'b0);
      if (rspAck !== 1'b1)
         waitOn(0);
      chk("hsAck", 16'h1, rspAck);
      chk("mcode", {`I2CM_MC_GROUP, 3'h5}, slvPrev);
      chk("starts", 16'h2, slvStarts - s0);
      xfer(`I2CM_OP_WRITE, 8'h5a, 1'b0, 1'b0, 1'b0);
      chk("hsHigh", 16'h1, lastHi >= 22 && lastHi <= 38);
      stop;
   end
   endtask
   task tArb;
   begin
      cmd(`I2CM_OP_START, 8'hff, 1'b0, 1'b0, 1'b0);
      waitOn(3);
      rivalPull = 1'b1;
      waitOn(2);
      repeat (4) @(negedge clk);
      chk("arbOe", 16'h0, {sclOe, sdaOe});
      rivalPull = 1'b0;
      waitOn(1);
      chk("arbFree", 16'h1, cmdReady);
   end
   endtask
   task tSpeed;
      integer s, q;
   begin
      for (s = 0; s < 3; s = s + 1)
      begin
         q = (s == 0) ? 500 : (s == 1) ? 125 : 50;
         speedSel = s[1:0];
         xfer(`I2CM_OP_START, {SLV, 1'b0}, 1'b0, 1'b0, 1'b0);
         chk("sclHigh", 16'h1, lastHi >= q * 3 / 2 && lastHi <= q * 5 / 2);
         stop;
      end
   end
   endtask
   initial
   begin
      {rst, cmdValid, cmdHs, cmdPoll, cmdNack, stretch, rivalPull, ackEn} = 8'h81;
      {cmdOp, cmdData, masterCode, hiCnt, lastHi, errorCnt, checked} = 0;
      speedSel = `I2CM_SPD_FP;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      tIdle;
      tWrite;
      tRead;
      tNack;
      tHs;
      tArb;
      tSpeed;
      endSim;
   end
endmodule
bind i2cm_master i2cm_master_chk i2cm_master_chk_i
(
   .clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
   .arbLost(arbLost), .busBusy(busBusy), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe)
);
